// >>> common/smtb_defines.vh
`ifndef SMTB_DEFINES_VH
`define SMTB_DEFINES_VH

// register byte offsets on the register bus
`define SMTB_OFF_CTRL 8'h00
`define SMTB_OFF_CLKDIV 8'h04
`define SMTB_OFF_PERIOD 8'h08
`define SMTB_OFF_COUNT 8'h0C
`define SMTB_OFF_IRQ_STAT 8'h10
`define SMTB_OFF_IRQ_EN 8'h14
`define SMTB_OFF_IRQ_CLR 8'h18
`define SMTB_OFF_ENABLE 8'h1C

// control register field positions
`define SMTB_CTRL_EVT_STAT 12
`define SMTB_CTRL_EVT_IEN 11
`define SMTB_CTRL_IMM_UPD 10
`define SMTB_CTRL_POL 9
`define SMTB_CTRL_SOEN 8
`define SMTB_CTRL_EXT_SYNC 7
`define SMTB_CTRL_SRC_HI 6
`define SMTB_CTRL_SRC_LO 4
`define SMTB_CTRL_PS_HI 3
`define SMTB_CTRL_PS_LO 0
`define SMTB_CTRL_WMASK 16'h0FFF

// reset values
`define SMTB_CTRL_RST 12'h000 // writable control bits only
`define SMTB_CLKDIV_RST 3'h0
`define SMTB_PERIOD_RST 16'hFFFF

// prescaler and sync source codes
`define SMTB_DIV_RESERVED 3'h7
`define SMTB_SRC_ONE 3'h0
`define SMTB_SRC_TWO 3'h1

// interrupt status bit positions
`define SMTB_IRQ_PERIOD 0
`define SMTB_IRQ_SYNC 1
`define SMTB_IRQ_EVENT 2

// sync output pulse length in clock cycles
`define SMTB_SYNC_PULSE_CYC 1

`endif

// >>> rtl/smtb_prescaler.v
`timescale 1ns/1ns
`include "smtb_defines.vh"

// divides the input clock into one-cycle ticks every 2**code clocks
module smtb_prescaler #(
    parameter WIDTH = 6
) (
    input wire clk,
    input wire rst_n,
    input wire run,
    input wire [2:0] code,
    output wire tick
);
    reg [WIDTH-1:0] div_q;
    reg [WIDTH-1:0] div_d;
    wire [WIDTH-1:0] limit;

    // limit is 2**code - 1; reserved code is held stopped
    assign limit = (code == `SMTB_DIV_RESERVED) ? {WIDTH{1'b0}} :
                   (({{(WIDTH-1){1'b0}}, 1'b1} << code) - {{(WIDTH-1){1'b0}}, 1'b1});
    assign tick = run && (code != `SMTB_DIV_RESERVED) && (div_q >= limit);

    // free divider counter, cleared when stopped
    always @* begin
        if (!run || tick) begin
            div_d = {WIDTH{1'b0}};
        end else begin
            div_d = div_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // divider register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= {WIDTH{1'b0}};
        end else begin
            div_q <= div_d;
        end
    end
endmodule // smtb_prescaler

// >>> rtl/smtb_time_base.v
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "smtb_defines.vh"

// Overview of operation
// - immediate update, or a disabled counter, writes period at once; otherwise it loads at the period boundary.
// - polarity bit set makes sync input and output active-low, else active-high.
// - sync output enable gates the sync output; cleared means output idles inactive.
// - three-bit prescaler divides by two to the code; code 111 reserved, default code 000 (divide by 1).
// - full sixteen-bit period sets the counter terminal count.
// - clock divider bits 15-3 ignore writes and read as zero.
module smtb_time_base (
    input wire CLOCK,
    input wire RESET_N,
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    output wire [1:0] S_AXI_BRESP,
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP,
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire SYNC_INPUT_ONE,
    input wire SYNC_INPUT_TWO,
    output wire SYNC_OUT,
    output wire SPECIAL_EVENT,
    output wire IRQ
);
    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_n;
    reg [11:0] ctrl_q;
    reg evt_stat_q;
    reg [2:0] clkdiv_q;
    reg [15:0] period_q;
    reg [15:0] period_buf_q;
    reg [15:0] count_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;
    reg enable_q;
    reg sync_prev_q;
    reg sync_out_q;
    reg [3:0] post_q;
    reg event_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;
    wire tick;
    wire wr_fire;
    wire rd_fire;
    wire sync_sel;
    wire sync_level;
    wire sync_edge;
    wire boundary;
    wire post_done;
    wire [15:0] wr_lo;
    wire [2:0] irq_evt;
    wire [2:0] irq_clr;
    wire [15:0] ctrl_wr;

    // merge byte lanes of the low half-word into an old value
    function [15:0] lane_merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            lane_merge = old;
            if (strb[0]) begin
                lane_merge[7:0] = data[7:0];
            end
            if (strb[1]) begin
                lane_merge[15:8] = data[15:8];
            end
        end
    endfunction

    // reset release through two flip-flops
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // write channel: address and data may arrive in either order
    assign S_AXI_AWREADY = !aw_hold_q && !bvalid_q;
    assign S_AXI_WREADY = !w_hold_q && !bvalid_q;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_lo = wdata_q[15:0];
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                case (awaddr_q[7:2])
                    6'h00, 6'h01, 6'h02, 6'h05, 6'h06, 6'h07: bresp_q <= 2'h0;
                    default: bresp_q <= 2'h2; // unmapped or read-only: slave error
                endcase
            end else if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // control write image; the status bit above the writable field stays out
    assign ctrl_wr = lane_merge({4'h0, ctrl_q}, wdata_q, wstrb_q) & `SMTB_CTRL_WMASK;

    // register writes
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `SMTB_CTRL_RST;
            clkdiv_q <= `SMTB_CLKDIV_RST;
            period_buf_q <= `SMTB_PERIOD_RST;
            irq_en_q <= 3'h0;
            enable_q <= 1'b0;
        end else if (wr_fire) begin
            case (awaddr_q)
                `SMTB_OFF_CTRL: ctrl_q <= ctrl_wr[11:0];
                `SMTB_OFF_CLKDIV: if (wstrb_q[0]) clkdiv_q <= wr_lo[2:0];
                `SMTB_OFF_PERIOD: period_buf_q <= lane_merge(period_buf_q, wdata_q, wstrb_q);
                `SMTB_OFF_IRQ_EN: if (wstrb_q[0]) irq_en_q <= wr_lo[2:0];
                `SMTB_OFF_ENABLE: if (wstrb_q[0]) enable_q <= wr_lo[0];
                default: enable_q <= enable_q;
            endcase
        end
    end

    // read channel, one cycle after address
    assign S_AXI_ARREADY = !rvalid_q;
    assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'h0;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= 2'h0;
            case (S_AXI_ARADDR)
                `SMTB_OFF_CTRL: rdata_q <= {19'h00000, evt_stat_q, ctrl_q};
                `SMTB_OFF_CLKDIV: rdata_q <= {29'h00000000, clkdiv_q};
                `SMTB_OFF_PERIOD: rdata_q <= {16'h0000, period_buf_q};
                `SMTB_OFF_COUNT: rdata_q <= {16'h0000, count_q};
                `SMTB_OFF_IRQ_STAT: rdata_q <= {29'h00000000, irq_stat_q};
                `SMTB_OFF_IRQ_EN: rdata_q <= {29'h00000000, irq_en_q};
                `SMTB_OFF_IRQ_CLR: rdata_q <= 32'h00000000;
                `SMTB_OFF_ENABLE: rdata_q <= {31'h00000000, enable_q};
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= 2'h2;
                end
            endcase
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
        end
    end

    // prescaler; code is expected stable while enabled
    smtb_prescaler #(
        .WIDTH(6)
    ) u_prescaler (
        .clk(CLOCK),
        .rst_n(rst_n),
        .run(enable_q),
        .code(clkdiv_q),
        .tick(tick)
    );

    // sync input select, polarity and edge detect
    assign sync_sel = (ctrl_q[`SMTB_CTRL_SRC_HI:`SMTB_CTRL_SRC_LO] == `SMTB_SRC_ONE) ?
        SYNC_INPUT_ONE : (ctrl_q[`SMTB_CTRL_SRC_HI:`SMTB_CTRL_SRC_LO] == `SMTB_SRC_TWO) ?
        SYNC_INPUT_TWO : ctrl_q[`SMTB_CTRL_POL]; // reserved codes never active
    assign sync_level = sync_sel ^ ctrl_q[`SMTB_CTRL_POL];
    assign sync_edge = ctrl_q[`SMTB_CTRL_EXT_SYNC] && sync_level && !sync_prev_q;

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev_q <= 1'b0;
        end else begin
            sync_prev_q <= sync_level;
        end
    end

    // counter with terminal count from the active period
    assign boundary = tick && (count_q >= period_q);

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            period_q <= `SMTB_PERIOD_RST;
        end else begin
            if (!enable_q || sync_edge) begin
                count_q <= 16'h0000;
            end else if (boundary) begin
                count_q <= 16'h0000;
            end else if (tick) begin
                count_q <= count_q + 16'h0001;
            end
            if (ctrl_q[`SMTB_CTRL_IMM_UPD] || boundary || !enable_q) begin
                period_q <= period_buf_q;
            end
        end
    end

    // sync output pulse at each boundary, polarity applied, gated by enable
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            sync_out_q <= 1'b0;
        end else begin
            sync_out_q <= boundary && ctrl_q[`SMTB_CTRL_SOEN];
        end
    end
    assign SYNC_OUT = sync_out_q ^ ctrl_q[`SMTB_CTRL_POL];

    // special event postscaler: one event every ps+1 boundaries
    assign post_done = boundary && (post_q == ctrl_q[`SMTB_CTRL_PS_HI:`SMTB_CTRL_PS_LO]);

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            post_q <= 4'h0;
            event_q <= 1'b0;
        end else begin
            event_q <= post_done;
            if (!enable_q || post_done) begin
                post_q <= 4'h0;
            end else if (boundary) begin
                post_q <= post_q + 4'h1;
            end
        end
    end
    assign SPECIAL_EVENT = event_q;

    // special event status: hardware set wins over software clear
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            evt_stat_q <= 1'b0;
        end else if (post_done && ctrl_q[`SMTB_CTRL_EVT_IEN]) begin
            evt_stat_q <= 1'b1;
        end else if (wr_fire && awaddr_q == `SMTB_OFF_IRQ_CLR && wstrb_q[0] &&
                     wr_lo[`SMTB_IRQ_EVENT]) begin
            evt_stat_q <= 1'b0;
        end
    end

    // sticky interrupt status, write-one-to-clear, set wins
    assign irq_evt = {post_done, sync_edge, boundary};
    assign irq_clr = (wr_fire && awaddr_q == `SMTB_OFF_IRQ_CLR && wstrb_q[0]) ?
        wr_lo[2:0] : 3'h0;

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 3'h0;
        end else begin
            irq_stat_q <= irq_evt | (irq_stat_q & ~irq_clr);
        end
    end
    assign IRQ = |(irq_stat_q & irq_en_q);
endmodule // smtb_time_base

// >>> test/smtb_sync_src.sv
`timescale 1ns/1ns
// external sync source: idles inactive, drives the active level on request
module smtb_sync_src (
    input wire clk,
    input wire pol,
    input wire [1:0] fire,
    output logic [1:0] sync
);
    initial sync = 2'h0;
    // inactive level is high when the polarity is inverted
    always @(posedge clk) begin
        sync <= fire ^ {2{pol}};
    end
endmodule // smtb_sync_src

// >>> test/smtb_time_base_assertions.sv
`timescale 1ns/1ns
// bus handshake and event pulse checks seen at the top ports
module smtb_chk (
    input wire CLOCK,
    input wire RESET_N,
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0] S_AXI_RRESP,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire SPECIAL_EVENT
);
    default clocking dc @(posedge CLOCK);
    endclocking
    default disable iff (!RESET_N);
    // answers stand until the master takes them
    AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA))
        else $error("read data moved");
    // one read at a time, answered on the next edge
    AST_AR_RDY: assert property (S_AXI_ARREADY != S_AXI_RVALID)
        else $error("read ready wrong");
    AST_R_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    AST_B_LAT: assert property (
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |-> ##[1:3] S_AXI_BVALID)
        else $error("write answer late");
    AST_AW_BLK: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while answer pending");
    AST_RRESP: assert property (S_AXI_RVALID |-> S_AXI_RRESP == 0 || S_AXI_RRESP == 2)
        else $error("bad read response");
    // special event pulses are at least nine clocks apart
    AST_EVT: assert property (SPECIAL_EVENT |=> !SPECIAL_EVENT [*8])
        else $error("event pulse too long");
    C_WR: cover property (S_AXI_BVALID && S_AXI_BREADY);
    C_ERR: cover property (S_AXI_RVALID && S_AXI_RRESP == 2);
    C_EVT: cover property (SPECIAL_EVENT);
endmodule // smtb_chk

bind smtb_time_base smtb_chk u_chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .SPECIAL_EVENT(SPECIAL_EVENT));

// >>> test/smtb_time_base_test.sv
`timescale 1ns/1ns
`include "smtb_defines.vh"
module smtb_time_base_test;
    logic clk = 0;
    logic rst_n = 0;
    logic [7:0] awa = 0;
    logic [7:0] ara = 0;
    logic [31:0] wd = 0;
    logic awv = 0;
    logic wv = 0;
    logic bre = 0;
    logic arv = 0;
    logic rre = 0;
    logic pol = 0;
    logic [1:0] fire = 0;
    logic [1:0] syn;
    logic [31:0] d;
    logic [1:0] rr, br;
    logic ta, tw, tb;
    wire awr, wrd, bv, arr, rv, so, irq, sev;
    wire [1:0] rresp, bresp;
    wire [31:0] rdat;
    int fails = 0;
    int compares = 0;
    int n;
    smtb_time_base DUT (.CLOCK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rre), .SYNC_INPUT_ONE(syn[0]), .SYNC_INPUT_TWO(syn[1]),
        .SYNC_OUT(so), .SPECIAL_EVENT(sev), .IRQ(irq));
    smtb_sync_src SRC (.clk(clk), .pol(pol), .fire(fire), .sync(syn));
    initial forever #10 clk = ~clk;
    // compare and count
    task automatic chk(input string nm, input [31:0] got, input [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    // bus write: ready sampled mid-cycle, released after the taking edge
    task automatic wr(input [7:0] a, input [31:0] v);
        @(posedge clk);
        awa <= a;
        wd <= v;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        forever begin
            @(negedge clk);
            ta = awr;
            tw = wrd;
            tb = bv;
            br = bresp;
            @(posedge clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
            if (tb) break;
        end
        bre <= 0;
    endtask
    // bus read
    task automatic rd(input [7:0] a, output [31:0] v);
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rre <= 1;
        forever begin
            @(negedge clk);
            ta = arr;
            tb = rv;
            v = rdat;
            rr = rresp;
            @(posedge clk);
            if (ta) arv <= 0;
            if (tb) break;
        end
        rre <= 0;
    endtask
    // cycles between two pulses of the sync output (ev 0) or the special event (ev 1)
    task automatic gap(input bit ev, output int c);
        int k;
        logic p;
        k = 0;
        c = 0;
        while (k < 2 && c < 2000) begin
            @(negedge clk);
            p = ev ? sev : so;
            c++;
            if (p) k++;
            if (p && k == 1) c = 0;
        end
    endtask
    // cycles out of forty with the sync output at level v
    task automatic cnt(input v, output int c);
        c = 0;
        repeat (40) begin
            @(negedge clk);
            if (so === v) c++;
        end
    endtask
    // reset values, unimplemented bits, unmapped place
    task automatic s_regs;
        rd(`SMTB_OFF_CLKDIV, d);
        chk("clkdiv rst", d, 32'h0);
        rd(`SMTB_OFF_PERIOD, d);
        chk("period rst", d, 32'hFFFF);
        wr(`SMTB_OFF_CLKDIV, 32'hFFFFFFFF);
        rd(`SMTB_OFF_CLKDIV, d);
        chk("clkdiv", d, 32'h7);
        wr(`SMTB_OFF_PERIOD, 32'hFFFFA5A8);
        rd(`SMTB_OFF_PERIOD, d);
        chk("period", d, 32'hA5A8);
        rd(8'h20, d);
        chk("unmapped", rr, 32'h2);
    endtask
    // period of the count for every legal prescaler code
    task automatic s_div;
        wr(`SMTB_OFF_PERIOD, 32'h10);
        wr(`SMTB_OFF_CTRL, 32'h100);
        for (int c = 0; c < 7; c++) begin
            wr(`SMTB_OFF_ENABLE, 32'h0);
            wr(`SMTB_OFF_CLKDIV, c);
            wr(`SMTB_OFF_ENABLE, 32'h1);
            gap(0, n);
            chk("gap", n, 17 << c);
        end
        wr(`SMTB_OFF_ENABLE, 32'h0);
        wr(`SMTB_OFF_CLKDIV, 32'h0);
    endtask
    // inverted polarity and output gating
    task automatic s_pol;
        wr(`SMTB_OFF_CTRL, 32'h300);
        cnt(1, n);
        chk("idle high", n, 40);
        wr(`SMTB_OFF_ENABLE, 32'h1);
        cnt(0, n);
        chk("low pulses", n > 0, 1);
        wr(`SMTB_OFF_CTRL, 32'h200);
        cnt(0, n);
        chk("gated", n, 0);
        wr(`SMTB_OFF_ENABLE, 32'h0);
    endtask
    // source select: {polarity, reset expected, source, fired inputs}
    task automatic s_sync;
        logic [7:0] t [6] = '{8'h41, 8'h02, 8'h52, 8'h11, 8'h23, 8'hC1};
        wr(`SMTB_OFF_PERIOD, 32'hFFF8);
        wr(`SMTB_OFF_ENABLE, 32'h1);
        foreach (t[i]) begin
            pol <= t[i][7];
            wr(`SMTB_OFF_CTRL, {22'h0, t[i][7], 3'h2, t[i][5:4], 4'h0});
            repeat (60) @(posedge clk);
            fire <= t[i][1:0];
            repeat (2) @(posedge clk);
            fire <= 2'h0;
            rd(`SMTB_OFF_COUNT, d);
            chk("sync reset", d < 20, t[i][6]);
        end
        rd(`SMTB_OFF_IRQ_STAT, d);
        chk("sync stat", d[1], 1);
        wr(`SMTB_OFF_ENABLE, 32'h0);
    endtask
    // postscaled special event, its status bit and clear, read-only write answer
    task automatic s_evt;
        wr(`SMTB_OFF_PERIOD, 32'h10);
        wr(`SMTB_OFF_CTRL, 32'h801);
        wr(`SMTB_OFF_ENABLE, 32'h1);
        gap(1, n);
        chk("event gap", n, 34);
        rd(`SMTB_OFF_CTRL, d);
        chk("event status", d, 32'h1801);
        rd(`SMTB_OFF_IRQ_STAT, d);
        chk("event irq", d[2], 1);
        wr(`SMTB_OFF_ENABLE, 32'h0);
        wr(`SMTB_OFF_IRQ_CLR, 32'h4);
        rd(`SMTB_OFF_CTRL, d);
        chk("status cleared", d, 32'h801);
        wr(`SMTB_OFF_COUNT, 32'h0);
        chk("ro write", br, 32'h2);
    endtask
    // deferred and immediate period load, interrupt raise, mask, clear
    task automatic s_upd;
        wr(`SMTB_OFF_IRQ_EN, 32'h1);
        wr(`SMTB_OFF_IRQ_CLR, 32'h7);
        wr(`SMTB_OFF_ENABLE, 32'h1);
        for (int e = 0; e < 2; e++) begin
            wr(`SMTB_OFF_CTRL, e << 10);
            repeat (30) @(posedge clk);
            wr(`SMTB_OFF_PERIOD, 32'h10);
            repeat (20) @(posedge clk);
            rd(`SMTB_OFF_IRQ_STAT, d);
            chk("boundary", d[0], e);
            chk("irq", irq, e);
        end
        wr(`SMTB_OFF_IRQ_EN, 32'h0);
        chk("masked", irq, 32'h0);
        wr(`SMTB_OFF_ENABLE, 32'h0);
        wr(`SMTB_OFF_IRQ_CLR, 32'h7);
        rd(`SMTB_OFF_IRQ_STAT, d);
        chk("cleared", d, 32'h0);
    endtask
    task automatic print_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        s_regs;
        s_div;
        s_pol;
        s_sync;
        s_upd;
        s_evt;
        print_verdict;
    end
    // hang guard
    initial begin
        #600000;
        fails++;
        print_verdict;
    end
endmodule // smtb_time_base_test
